//--- verilog/integer_divide_unit.sv
// Integer divide unit: signed and unsigned word divide with read interlock
//
// Contract
// - Signed divide treats dividend and divisor as two's-complement 32-bit values.
// - Unsigned divide treats both 32-bit operands as plain unsigned values.
// - On completion the quotient and remainder registers both take the new results.
// - No divide ever raises an exception, whatever the operands.
// - A zero divisor leaves unspecified values in both result registers.
// - The divide runs over many cycles while independent work continues outside.
// - A result read issued while a divide is outstanding waits and then returns new values.
// - Overlapping a divide with other work never changes any visible result.
// - A result read right before a divide needs no spacing and returns the old values.
`timescale 1ns/1ps
`include "divide_cfg.svh"

module integer_divide_unit #(
    parameter int WIDTH = `DIV_WORD_WIDTH
) (
    input  wire logic                   clk_sys,
    input  wire logic                   arst_n,
    input  wire logic                   issue_valid,
    input  wire divide_pkg::div_issue_s issue,
    input  wire logic                   read_valid,
    input  wire divide_pkg::read_req_s  read_req,
    output logic                        busy,
    output logic                        div_done,
    output logic                        read_ack,
    output logic [WIDTH-1:0]            read_data,
    output logic [WIDTH-1:0]            quotient_register,
    output logic [WIDTH-1:0]            remainder_register
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    divide_pkg::div_state_e state;
    divide_pkg::div_state_e next_state;
    logic                   neg_quo;
    logic                   neg_rem;
    logic [WIDTH-1:0]       mag_a;
    logic [WIDTH-1:0]       mag_b;
    logic                   go;
    logic                   next_neg_quo;
    logic                   next_neg_rem;
    logic [WIDTH-1:0]       next_mag_a;
    logic [WIDTH-1:0]       next_mag_b;
    logic                   next_go;
    logic                   next_busy;
    logic                   next_div_done;
    logic [WIDTH-1:0]       next_quotient_register;
    logic [WIDTH-1:0]       next_remainder_register;
    logic                   next_read_ack;
    logic [WIDTH-1:0]       next_read_data;
    logic                   is_signed;
    logic                   sign_a;
    logic                   sign_b;
    logic                   core_done;
    logic [WIDTH-1:0]       core_quo;
    logic [WIDTH-1:0]       core_rem;

    // ------------------------------------------------------------
    // Operand decode
    // ------------------------------------------------------------
    // Sign bits only count for the signed operation
    assign is_signed = (issue.op == divide_pkg::signed_word_divide_op);
    assign sign_a    = is_signed & issue.dividend_source_register[WIDTH-1];
    assign sign_b    = is_signed & issue.divisor_source_register[WIDTH-1];

    // ------------------------------------------------------------
    // Unsigned iteration core
    // ------------------------------------------------------------
    divide_iter #(
        .WIDTH (WIDTH)
    ) u_iter (
        .clk_sys   (clk_sys),
        .arst_n    (arst_n),
        .go        (go),
        .dividend  (mag_a),
        .divisor   (mag_b),
        .done      (core_done),
        .quotient  (core_quo),
        .remainder (core_rem)
    );

    // ------------------------------------------------------------
    // Divide sequencer
    // ------------------------------------------------------------
    // Accepts one divide when idle, runs it in the core, fixes the signs,
    // then writes both result registers in the same cycle
    always_comb begin
        next_state              = state;
        next_neg_quo            = neg_quo;
        next_neg_rem            = neg_rem;
        next_mag_a              = mag_a;
        next_mag_b              = mag_b;
        next_go                 = 1'b0;
        next_busy               = busy;
        next_div_done           = 1'b0;
        next_quotient_register  = quotient_register;
        next_remainder_register = remainder_register;
        unique case (state)
            divide_pkg::ST_IDLE: begin
                if (issue_valid) begin
                    // Magnitudes; the most negative value maps onto itself unsigned
                    next_mag_a   = sign_a ? WIDTH'(-issue.dividend_source_register)
                                          : issue.dividend_source_register;
                    next_mag_b   = sign_b ? WIDTH'(-issue.divisor_source_register)
                                          : issue.divisor_source_register;
                    next_neg_quo = sign_a ^ sign_b;
                    next_neg_rem = sign_a;
                    next_go      = 1'b1;
                    next_busy    = 1'b1;
                    next_state   = divide_pkg::ST_CALC;
                end
            end
            divide_pkg::ST_CALC: begin
                // Core always ends after a fixed step count, any operands
                if (core_done) begin
                    next_state = divide_pkg::ST_FIX;
                end
            end
            divide_pkg::ST_FIX: begin
                next_quotient_register  = neg_quo ? WIDTH'(-core_quo) : core_quo;
                next_remainder_register = neg_rem ? WIDTH'(-core_rem) : core_rem;
                next_busy               = 1'b0;
                next_div_done           = 1'b1;
                next_state              = divide_pkg::ST_IDLE;
            end
            default: begin
                next_busy  = 1'b0;
                next_state = divide_pkg::ST_IDLE;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state              <= divide_pkg::ST_IDLE;
            neg_quo            <= 1'b0;
            neg_rem            <= 1'b0;
            mag_a              <= '0;
            mag_b              <= '0;
            go                 <= 1'b0;
            busy               <= 1'b0;
            div_done           <= 1'b0;
            quotient_register  <= `DIV_QUOTIENT_RST;
            remainder_register <= `DIV_REMAINDER_RST;
        end else begin
            state              <= next_state;
            neg_quo            <= next_neg_quo;
            neg_rem            <= next_neg_rem;
            mag_a              <= next_mag_a;
            mag_b              <= next_mag_b;
            go                 <= next_go;
            busy               <= next_busy;
            div_done           <= next_div_done;
            quotient_register  <= next_quotient_register;
            remainder_register <= next_remainder_register;
        end
    end

    // ------------------------------------------------------------
    // Result read port with interlock
    // ------------------------------------------------------------
    // A read is taken only while no divide is outstanding, so it either
    // sees the old pair (issued before the divide) or the new pair
    always_comb begin
        next_read_ack  = 1'b0;
        next_read_data = read_data;
        if (read_valid && !busy) begin
            next_read_ack  = 1'b1;
            if (read_req.sel == divide_pkg::move_from_remainder_op) begin
                next_read_data = remainder_register;
            end else begin
                next_read_data = quotient_register;
            end
        end
    end

    // Read answer registers
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            read_ack  <= 1'b0;
            read_data <= '0;
        end else begin
            read_ack  <= next_read_ack;
            read_data <= next_read_data;
        end
    end

endmodule

//--- pkg/divide_cfg.svh
// Constants of the integer divide unit: widths, step counts, reset values
`ifndef DIVIDE_CFG_SVH
`define DIVIDE_CFG_SVH

// ------------------------------------------------------------
// Datapath sizing
// ------------------------------------------------------------
`define DIV_WORD_WIDTH   32
`define DIV_SIGN_BIT     31
`define DIV_STEP_COUNT   32

// ------------------------------------------------------------
// Reset values of the result registers
// ------------------------------------------------------------
`define DIV_QUOTIENT_RST  32'h0000_0000
`define DIV_REMAINDER_RST 32'h0000_0000

`endif

//--- pkg/divide_pkg.sv
// Types shared by the integer divide unit and its checker, pipeline model and bench
package divide_pkg;

    // ------------------------------------------------------------
    // Operation and selector encodings
    // ------------------------------------------------------------
    typedef enum logic {
        signed_word_divide_op   = 1'b0,
        unsigned_word_divide_op = 1'b1
    } div_op_e;

    typedef enum logic {
        move_from_quotient_op  = 1'b0,
        move_from_remainder_op = 1'b1
    } read_sel_e;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CALC = 2'b01,
        ST_FIX  = 2'b10
    } div_state_e;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        div_op_e     op;
        logic [31:0] dividend_source_register;
        logic [31:0] divisor_source_register;
    } div_issue_s;

    typedef struct packed {
        read_sel_e   sel;
    } read_req_s;

endpackage

//--- verilog/divide_iter.sv
// Unsigned restoring divide core, one quotient bit per clock
`timescale 1ns/1ps
`include "divide_cfg.svh"

module divide_iter #(
    parameter int WIDTH = `DIV_WORD_WIDTH
) (
    input  wire logic             clk_sys,
    input  wire logic             arst_n,
    input  wire logic             go,
    input  wire logic [WIDTH-1:0] dividend,
    input  wire logic [WIDTH-1:0] divisor,
    output logic                  done,
    output logic [WIDTH-1:0]      quotient,
    output logic [WIDTH-1:0]      remainder
);

    localparam int CW = $clog2(WIDTH + 1);
    localparam logic [CW-1:0] LAST = CW'(WIDTH - 1);

    logic             running;
    logic [CW-1:0]    count;
    logic [WIDTH-1:0] dvs;
    logic             next_running;
    logic [CW-1:0]    next_count;
    logic [WIDTH-1:0] next_dvs;
    logic             next_done;
    logic [WIDTH-1:0] next_quotient;
    logic [WIDTH-1:0] next_remainder;
    logic [WIDTH:0]   shifted;
    logic [WIDTH:0]   diff;

    // ------------------------------------------------------------
    // Shift-subtract step
    // ------------------------------------------------------------
    // A zero divisor never borrows: all-ones quotient, dividend as remainder
    always_comb begin
        next_running   = running;
        next_count     = count;
        next_dvs       = dvs;
        next_done      = 1'b0;
        next_quotient  = quotient;
        next_remainder = remainder;
        shifted        = {remainder, quotient[WIDTH-1]};
        diff           = shifted - {1'b0, dvs};
        if (go) begin
            next_running   = 1'b1;
            next_count     = '0;
            next_dvs       = divisor;
            next_quotient  = dividend;
            next_remainder = '0;
        end else if (running) begin
            if (!diff[WIDTH]) begin
                next_remainder = diff[WIDTH-1:0];
            end else begin
                next_remainder = shifted[WIDTH-1:0];
            end
            next_quotient = {quotient[WIDTH-2:0], ~diff[WIDTH]};
            next_count    = count + CW'(1);
            if (count == LAST) begin
                next_running = 1'b0;
                next_done    = 1'b1;
            end
        end
    end

    // Step registers
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            running   <= 1'b0;
            count     <= '0;
            dvs       <= '0;
            done      <= 1'b0;
            quotient  <= '0;
            remainder <= '0;
        end else begin
            running   <= next_running;
            count     <= next_count;
            dvs       <= next_dvs;
            done      <= next_done;
            quotient  <= next_quotient;
            remainder <= next_remainder;
        end
    end

endmodule

//--- verification/integer_divide_unit_sva.sv
// Port timing checker of the integer divide unit
`timescale 1ns/1ps
`include "divide_cfg.svh"
module integer_divide_unit_sva #(
    parameter int WIDTH = `DIV_WORD_WIDTH
) (
    input wire logic                   clk_sys,
    input wire logic                   arst_n,
    input wire logic                   issue_valid,
    input wire divide_pkg::div_issue_s issue,
    input wire logic                   read_valid,
    input wire divide_pkg::read_req_s  read_req,
    input wire logic                   busy,
    input wire logic                   div_done,
    input wire logic                   read_ack,
    input wire logic [WIDTH-1:0]       read_data,
    input wire logic [WIDTH-1:0]       quotient_register,
    input wire logic [WIDTH-1:0]       remainder_register
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    logic [5:0] busy_cnt;
    logic [5:0] next_busy_cnt;
    // Length of the current busy stretch
    always_comb next_busy_cnt = busy ? busy_cnt + 6'h1 : 6'h0;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) busy_cnt <= 6'h0;
        else busy_cnt <= next_busy_cnt;
    end
    AST_DIV_LATENCY: assert property (issue_valid && !busy |-> ##36 div_done)
        else $error("divide did not finish 36 cycles after issue");
    AST_BUSY_MAX: assert property (busy_cnt <= 6'h23)
        else $error("busy held longer than one divide");
    AST_BUSY_END: assert property ($fell(busy) |-> div_done)
        else $error("busy fell without results");
    AST_DONE_PULSE: assert property (div_done |=> !div_done)
        else $error("done longer than one cycle");
    AST_DONE_IDLE: assert property (div_done |-> !busy)
        else $error("done while still busy");
    AST_REG_UPDATE: assert property ($changed(quotient_register) ||
        $changed(remainder_register) |-> div_done)
        else $error("result registers changed outside completion");
    AST_READ_ANSWER: assert property (read_valid && !busy |=> read_ack && read_data ==
        ($past(read_req.sel) == divide_pkg::move_from_remainder_op ?
        $past(remainder_register) : $past(quotient_register)))
        else $error("read answer wrong");
    AST_READ_STALL: assert property (read_ack |-> $past(read_valid && !busy))
        else $error("read answered while busy");
    // Main scenarios
    cover property (issue_valid && !busy);
    cover property (read_valid && busy);
    cover property (issue_valid && read_valid && !busy);
endmodule

//--- verification/pipe_issue_model.sv
// Pipeline side model: holds each request until the unit takes it
`timescale 1ns/1ps
module pipe_issue_model (
    input  wire logic              clk_sys,
    input  wire logic              busy,
    output divide_pkg::div_issue_s issue,
    output logic                   issue_valid,
    output divide_pkg::read_req_s  read_req,
    output logic                   read_valid
);
    // Idle values at time zero
    initial begin
        issue_valid = 1'b0;
        issue = '0;
        read_valid = 1'b0;
        read_req = '0;
    end
    // Divide held until an edge with the unit idle, no spacing after reads
    task automatic send_div(input divide_pkg::div_issue_s d);
        @(negedge clk_sys);
        issue <= d;
        issue_valid <= 1'b1;
        do @(posedge clk_sys); while (busy !== 1'b0);
        @(negedge clk_sys);
        issue_valid <= 1'b0;
        issue <= divide_pkg::div_issue_s'(~d); // Released lines lose the value
    endtask
    // Read held until taken; stalls while a divide is outstanding
    task automatic send_read(input divide_pkg::read_sel_e s);
        @(negedge clk_sys);
        read_req.sel <= s;
        read_valid <= 1'b1;
        do @(posedge clk_sys); while (busy !== 1'b0);
        @(negedge clk_sys);
        read_valid <= 1'b0;
        read_req.sel <= divide_pkg::read_sel_e'(~s);
    endtask
endmodule

//--- verification/test_integer_divide_unit.sv
// Self-checking bench of the integer divide unit
`timescale 1ns/1ps
`include "divide_cfg.svh"
module test_integer_divide_unit;
    typedef struct packed {logic chk; logic [31:0] quo; logic [31:0] rem;} note_s;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic issue_valid, read_valid, busy, div_done, read_ack;
    divide_pkg::div_issue_s issue;
    divide_pkg::read_req_s  read_req;
    logic [31:0] read_data, quotient_register, remainder_register;
    logic [31:0] arch_quo, arch_rem;
    logic        arch_known;
    note_s       div_notes[$];
    note_s       read_notes[$];
    note_s       n;
    int          n_errors, num_checks, cycles;
    logic [64:0] cases [8] = '{{1'b0, 32'hffff_fff9, 32'h0000_0002},
        {1'b0, 32'h0000_0007, 32'hffff_fffe}, {1'b0, 32'h8000_0000, 32'hffff_ffff},
        {1'b0, 32'h0000_0005, 32'h0000_0000}, {1'b1, 32'hffff_ffff, 32'h0000_0002},
        {1'b1, 32'h8000_0000, 32'hffff_ffff}, {1'b1, 32'h0000_0009, 32'h0000_0000},
        {1'b0, 32'hffff_fff7, 32'hffff_fffc}};

    always #5 clk_sys = ~clk_sys;

    integer_divide_unit dut (.clk_sys(clk_sys), .arst_n(arst_n), .issue_valid(issue_valid),
        .issue(issue), .read_valid(read_valid), .read_req(read_req), .busy(busy),
        .div_done(div_done), .read_ack(read_ack), .read_data(read_data),
        .quotient_register(quotient_register), .remainder_register(remainder_register));
    pipe_issue_model pipe (.clk_sys(clk_sys), .busy(busy), .issue(issue),
        .issue_valid(issue_valid), .read_req(read_req), .read_valid(read_valid));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Reference: signed truncates toward zero, most negative by minus one wraps
    function automatic logic [63:0] ref_div(input logic op, input logic [31:0] a, b);
        if (op) return {a % b, a / b};
        if (a == 32'h8000_0000 && b == 32'hffff_ffff) return {32'h0, 32'h8000_0000};
        return {32'($signed(a) % $signed(b)), 32'($signed(a) / $signed(b))};
    endfunction
    // Zero divisor leaves unspecified results, so those are not compared
    task automatic do_div(input logic op, input logic [31:0] a, input logic [31:0] b);
        logic [63:0] r;
        r = ref_div(op, a, b);
        arch_known = (b != 32'h0);
        arch_quo = r[31:0];
        arch_rem = r[63:32];
        div_notes.push_back('{arch_known, arch_quo, arch_rem});
        pipe.send_div('{divide_pkg::div_op_e'(op), a, b});
    endtask
    task automatic do_read(input logic sel);
        read_notes.push_back('{arch_known, sel ? arch_rem : arch_quo, 32'h0});
        pipe.send_read(divide_pkg::read_sel_e'(sel));
    endtask

    // Result watcher takes the oldest note whenever an answer appears
    always @(posedge clk_sys) begin
        #1;
        if (div_done === 1'b1) begin
            n = div_notes.pop_front();
            if (n.chk) check(quotient_register, n.quo);
            if (n.chk) check(remainder_register, n.rem);
        end
        if (read_ack === 1'b1) begin
            n = read_notes.pop_front();
            if (n.chk) check(read_data, n.quo);
        end
    end
    // Hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    initial begin
        void'($urandom(32'hc07d));
        repeat (10) @(posedge clk_sys);
        @(negedge clk_sys);
        arst_n = 1'b1;
        check(quotient_register, `DIV_QUOTIENT_RST);
        check(remainder_register, `DIV_REMAINDER_RST);
        {arch_known, arch_quo, arch_rem} = {1'b1, `DIV_QUOTIENT_RST, `DIV_REMAINDER_RST};
        do_read(1'b1);
        // Corner operands, each followed by a read that stalls behind the divide and a second read taken at once
        for (int i = 0; i < 8; i++) begin
            do_div(cases[i][64], cases[i][63:32], cases[i][31:0]);
            do_read(1'b0);
            do_read(1'b1);
        end
        // Random operands of both kinds
        for (int i = 0; i < 16; i++) begin
            do_div(1'($urandom), $urandom, ($urandom >> ($urandom % 32)) | 32'h1);
            do_read(1'($urandom));
        end
        // Read and divide taken on one edge, then a divide held while busy
        fork
            do_read(1'b1);
            begin
                #1;
                do_div(1'b1, 32'h0000_0064, 32'h0000_0007);
            end
        join
        do_div(1'b0, 32'h0000_0064, 32'hffff_fff9);
        do_read(1'b0);
        do_read(1'b1);
        while (div_notes.size() + read_notes.size() > 0) @(posedge clk_sys);
        tally_and_finish();
    end
endmodule

bind integer_divide_unit integer_divide_unit_sva #(.WIDTH(WIDTH)) u_sva (
    .clk_sys(clk_sys), .arst_n(arst_n), .issue_valid(issue_valid), .issue(issue),
    .read_valid(read_valid), .read_req(read_req), .busy(busy), .div_done(div_done),
    .read_ack(read_ack), .read_data(read_data), .quotient_register(quotient_register),
    .remainder_register(remainder_register));
